// [rtl/i2c_target_map.svh]
// Purpose: Constants for the register-pointer I2C target.
// Assumes: Core clock of 100 MHz; the serial clock is sampled, not used as a clock.
// Notes: Offsets are register pointer values on the serial bus.
`ifndef I2C_TARGET_MAP_SVH
`define I2C_TARGET_MAP_SVH

// Bus address and pointer
`define TARGET_ADDR 7'h32
`define PTR_RESET 8'h00
`define PTR_STEP 8'h01
`define REG_COUNT 256

// Scratch registers for access checks
`define SCRATCH_TEST_0_OFS 8'h88
`define SCRATCH_TEST_1_OFS 8'h89
`define SCRATCH_TEST_2_OFS 8'h8A
`define SCRATCH_TEST_3_OFS 8'h8B

// Write staging buffer
`define WR_FIFO_DEPTH 8
`define WR_FIFO_WIDTH 16

// Bit counter values
`define BIT_CNT_ZERO 4'h0
`define BIT_CNT_FULL 4'h8

// Serial clock limits and derived core cycles per half period
`define CLK_KHZ 100000
`define SCL_STD_KHZ 100
`define SCL_FAST_KHZ 400
`define SCL_HALF_MIN_CYC (`CLK_KHZ / (2 * `SCL_FAST_KHZ))

`endif

// [rtl/i2c_target_pkg.sv]
// Purpose: Types for the register-pointer I2C target.
// Assumes: Constants live in i2c_target_map.svh.
// Notes: One-hot state codes are written out.
package i2c_target_pkg;

   // Transfer phases of the target
   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_ADDR = 9'h002,
      ST_ADDR_ACK = 9'h004,
      ST_PTR = 9'h008,
      ST_PTR_ACK = 9'h010,
      ST_WDATA = 9'h020,
      ST_WDATA_ACK = 9'h040,
      ST_RDATA = 9'h080,
      ST_RDATA_ACK = 9'h100
   } tgt_state_type;

   // Whole state of the target engine
   typedef struct packed {
      logic scl_s1;
      logic scl_s2;
      logic scl_d;
      logic sda_s1;
      logic sda_s2;
      logic sda_d;
      tgt_state_type state;
      logic [3:0] bit_cnt;
      logic [7:0] shift;
      logic rw;
      logic host_nack;
      logic [7:0] ptr;
      logic drive;
      logic push_valid;
      logic [15:0] push_data;
      logic busy;
   } tgt_regs_type;

endpackage

// [rtl/wr_fifo.sv]
// Purpose: Staging FIFO between the serial engine and the register bank.
// Assumes: Single clock; in_valid is only raised while in_ready is high.
// Notes: Width and depth are parameters; full and empty are exact.
module wr_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Filling side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Draining side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0] cnt_reg;
   logic push;
   logic pop;

   // Handshakes and flags
   assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid = (cnt_reg != '0);
   assign out_data = mem[rd_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Pointers and fill count
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end
      else
      begin
         if (push)
            wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : AW'(wr_reg + 1'b1);
         if (pop)
            rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : AW'(rd_reg + 1'b1);
         if (push && !pop)
            cnt_reg <= (AW+1)'(cnt_reg + 1'b1);
         else if (pop && !push)
            cnt_reg <= (AW+1)'(cnt_reg - 1'b1);
      end
   end

   // Storage, not reset
   always_ff @(posedge clk)
   begin
      if (push)
         mem[wr_reg] <= in_data;
   end

endmodule

// [rtl/reg_bank.sv]
// Purpose: The 256-entry bank of 8-bit registers behind the pointer.
// Assumes: One write port, two registered read ports.
// Notes: Contents are undefined until written.
`include "i2c_target_map.svh"

module reg_bank (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Write port
   input wire logic wr_en,
   input wire logic [7:0] wr_addr,
   input wire logic [7:0] wr_data,
   // Serial side read port
   input wire logic [7:0] rd_addr_a,
   output logic [7:0] rd_data_a,
   // Core side read port
   input wire logic [7:0] rd_addr_b,
   output logic [7:0] rd_data_b
);
   logic [7:0] mem [`REG_COUNT];

   // Array write
   always_ff @(posedge clk)
   begin
      if (wr_en)
         mem[wr_addr] <= wr_data;
   end

   // Registered reads
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rd_data_a <= 8'h00;
         rd_data_b <= 8'h00;
      end
      else
      begin
         rd_data_a <= mem[rd_addr_a];
         rd_data_b <= mem[rd_addr_b];
      end
   end

endmodule

// [rtl/i2c_target.sv]
// Purpose: I2C target giving a host access to a bank of 8-bit registers.
// Assumes: scl and sda arrive asynchronously and are oversampled by clk.
// Notes: Writes pass a staging FIFO; a full FIFO answers the byte with NACK.
`include "i2c_target_map.svh"

// Notes on behaviour
// - Serves standard mode to 100 kHz and fast mode to 400 kHz.
// - Acknowledges only target address 0x32; other addresses are ignored.
// - Every serial register access uses the register chosen by the pointer; the core side reads at core_addr.
// - Host loads the pointer in a write before any register access.
// - Pointer advances by one after each register byte read or accepted for writing; a write byte refused by a full FIFO leaves it.
// - Pointer is 8 bits and wraps from 0xFF to 0x00.
module i2c_target
   import i2c_target_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Serial pins, open drain
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // Core side
   input wire logic bank_hold,
   input wire logic [7:0] core_addr,
   output logic [7:0] core_rdata,
   output logic [7:0] ptr_out,
   output logic busy
);
   tgt_regs_type st_reg;
   tgt_regs_type st_next;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic fifo_ready;
   logic fifo_valid;
   logic [15:0] fifo_data;
   logic [7:0] bank_rdata;

   // Bus events from the second synchroniser stage only
   assign scl_rise = st_reg.scl_s2 && !st_reg.scl_d;
   assign scl_fall = !st_reg.scl_s2 && st_reg.scl_d;
   assign start_cond = st_reg.scl_s2 && st_reg.scl_d && !st_reg.sda_s2 && st_reg.sda_d;
   assign stop_cond = st_reg.scl_s2 && st_reg.scl_d && st_reg.sda_s2 && !st_reg.sda_d;

   // Pin and status outputs
   assign sda_out = 1'b0;
   assign sda_oe_n = !st_reg.drive;
   assign ptr_out = st_reg.ptr;
   assign busy = st_reg.busy;

   // Next state of the serial engine
   always_comb
   begin
      st_next = st_reg;
      st_next.scl_s1 = scl;
      st_next.scl_s2 = st_reg.scl_s1;
      st_next.scl_d = st_reg.scl_s2;
      st_next.sda_s1 = sda_in;
      st_next.sda_s2 = st_reg.sda_s1;
      st_next.sda_d = st_reg.sda_s2;
      st_next.push_valid = 1'b0;
      if (scl_rise)
         st_next.bit_cnt = 4'(st_reg.bit_cnt + 1'b1);
      if (start_cond)
      begin
         // Start or repeated start
         st_next.state = ST_ADDR;
         st_next.bit_cnt = `BIT_CNT_ZERO;
         st_next.drive = 1'b0;
      end
      else if (stop_cond)
      begin
         st_next.state = ST_IDLE;
         st_next.drive = 1'b0;
      end
      else
      begin
         unique case (st_reg.state)
            ST_IDLE:
            begin
               st_next.drive = 1'b0;
            end
            ST_ADDR:
            begin
               if (scl_rise)
                  st_next.shift = {st_reg.shift[6:0], st_reg.sda_s2};
               if (scl_fall && st_reg.bit_cnt == `BIT_CNT_FULL)
               begin
                  if (st_reg.shift[7:1] == `TARGET_ADDR)
                  begin
                     st_next.rw = st_reg.shift[0];
                     st_next.drive = 1'b1;
                     st_next.state = ST_ADDR_ACK;
                  end
                  else
                     st_next.state = ST_IDLE;
               end
            end
            ST_ADDR_ACK:
            begin
               if (scl_fall)
               begin
                  st_next.bit_cnt = `BIT_CNT_ZERO;
                  if (st_reg.rw)
                  begin
                     st_next.shift = bank_rdata;
                     st_next.drive = !bank_rdata[7];
                     st_next.state = ST_RDATA;
                  end
                  else
                  begin
                     st_next.drive = 1'b0;
                     st_next.state = ST_PTR;
                  end
               end
            end
            ST_PTR:
            begin
               if (scl_rise)
                  st_next.shift = {st_reg.shift[6:0], st_reg.sda_s2};
               if (scl_fall && st_reg.bit_cnt == `BIT_CNT_FULL)
               begin
                  st_next.ptr = st_reg.shift;
                  st_next.drive = 1'b1;
                  st_next.state = ST_PTR_ACK;
               end
            end
            ST_PTR_ACK, ST_WDATA_ACK:
            begin
               if (scl_fall)
               begin
                  st_next.bit_cnt = `BIT_CNT_ZERO;
                  st_next.drive = 1'b0;
                  st_next.state = ST_WDATA;
               end
            end
            ST_WDATA:
            begin
               if (scl_rise)
                  st_next.shift = {st_reg.shift[6:0], st_reg.sda_s2};
               if (scl_fall && st_reg.bit_cnt == `BIT_CNT_FULL)
               begin
                  if (fifo_ready)
                  begin
                     st_next.push_valid = 1'b1;
                     st_next.push_data = {st_reg.ptr, st_reg.shift};
                     st_next.ptr = 8'(st_reg.ptr + `PTR_STEP);
                     st_next.drive = 1'b1;
                     st_next.state = ST_WDATA_ACK;
                  end
                  else
                     st_next.state = ST_IDLE;
               end
            end
            ST_RDATA:
            begin
               if (scl_fall)
               begin
                  if (st_reg.bit_cnt == `BIT_CNT_FULL)
                  begin
                     st_next.drive = 1'b0;
                     st_next.state = ST_RDATA_ACK;
                  end
                  else
                  begin
                     st_next.shift = {st_reg.shift[6:0], 1'b0};
                     st_next.drive = !st_reg.shift[6];
                  end
               end
            end
            ST_RDATA_ACK:
            begin
               if (scl_rise)
               begin
                  st_next.host_nack = st_reg.sda_s2;
                  st_next.ptr = 8'(st_reg.ptr + `PTR_STEP);
               end
               if (scl_fall)
               begin
                  if (st_reg.host_nack)
                  begin
                     st_next.drive = 1'b0;
                     st_next.state = ST_IDLE;
                  end
                  else
                  begin
                     st_next.bit_cnt = `BIT_CNT_ZERO;
                     st_next.shift = bank_rdata;
                     st_next.drive = !bank_rdata[7];
                     st_next.state = ST_RDATA;
                  end
               end
            end
            default:
            begin
               st_next.drive = 1'b0;
               st_next.state = ST_IDLE;
            end
         endcase
      end
      st_next.busy = (st_next.state != ST_IDLE);
   end

   // State register, bus lines idle high at reset
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_reg <= '0;
         st_reg.scl_s1 <= 1'b1;
         st_reg.scl_s2 <= 1'b1;
         st_reg.scl_d <= 1'b1;
         st_reg.sda_s1 <= 1'b1;
         st_reg.sda_s2 <= 1'b1;
         st_reg.sda_d <= 1'b1;
         st_reg.state <= ST_IDLE;
         st_reg.ptr <= `PTR_RESET;
      end
      else
         st_reg <= st_next;
   end

   // Staging FIFO for register writes
   wr_fifo #(
      .WIDTH(`WR_FIFO_WIDTH),
      .DEPTH(`WR_FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .nrst(nrst),
      .in_valid(st_reg.push_valid),
      .in_data(st_reg.push_data),
      .in_ready(fifo_ready),
      .out_valid(fifo_valid),
      .out_data(fifo_data),
      .out_ready(!bank_hold)
   );

   reg_bank u_bank (
      .clk(clk),
      .nrst(nrst),
      .wr_en(fifo_valid && !bank_hold),
      .wr_addr(fifo_data[15:8]),
      .wr_data(fifo_data[7:0]),
      .rd_addr_a(st_reg.ptr),
      .rd_data_a(bank_rdata),
      .rd_addr_b(core_addr),
      .rd_data_b(core_rdata)
   );

   // Checks on the serial engine
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   sequence addr_done_s;
      st_reg.state == ST_ADDR && scl_fall && st_reg.bit_cnt == `BIT_CNT_FULL && !start_cond;
   endsequence

   sequence wdata_done_s;
      st_reg.state == ST_WDATA && scl_fall && st_reg.bit_cnt == `BIT_CNT_FULL && !stop_cond;
   endsequence

   a_addr_match: assert property (addr_done_s ##0 st_reg.shift[7:1] == `TARGET_ADDR
      |=> st_reg.state == ST_ADDR_ACK && !sda_oe_n)
      else $error("own address not acknowledged");

   a_addr_ignore: assert property (addr_done_s ##0 st_reg.shift[7:1] != `TARGET_ADDR
      |=> st_reg.state == ST_IDLE && sda_oe_n)
      else $error("foreign address not ignored");

   a_ptr_load: assert property (st_reg.state == ST_PTR && scl_fall
      && st_reg.bit_cnt == `BIT_CNT_FULL && !start_cond && !stop_cond
      |=> ptr_out == $past(st_reg.shift) && !sda_oe_n)
      else $error("pointer not loaded from first byte");

   a_write_push: assert property (wdata_done_s ##0 fifo_ready
      |=> st_reg.push_valid && st_reg.push_data[15:8] == $past(st_reg.ptr)
      && ptr_out == 8'($past(st_reg.ptr) + `PTR_STEP) ##1 !st_reg.push_valid)
      else $error("write not staged at pointer");

   a_read_advance: assert property (st_reg.state == ST_RDATA_ACK && scl_rise
      && !start_cond && !stop_cond
      |=> ptr_out == 8'($past(st_reg.ptr) + `PTR_STEP))
      else $error("pointer did not advance after read");

   a_nack_release: assert property (st_reg.state == ST_RDATA_ACK && scl_fall
      && st_reg.host_nack && !start_cond && !stop_cond
      |=> sda_oe_n && st_reg.state == ST_IDLE ##1 sda_oe_n)
      else $error("data line held after host NACK");

   a_read_bit: assert property (st_reg.state == ST_RDATA && scl_fall
      && st_reg.bit_cnt < `BIT_CNT_FULL && !start_cond && !stop_cond
      |=> sda_oe_n == $past(st_reg.shift[6]))
      else $error("read bit driven wrongly");

   a_drive_low_scl: assert property ($fell(sda_oe_n) |-> !st_reg.scl_s2)
      else $error("data line taken while clock high");

   a_full_nack: assert property (wdata_done_s ##0 !fifo_ready
      |=> sda_oe_n && !st_reg.push_valid)
      else $error("full staging buffer still acknowledged");

   a_release_low_scl: assert property ($rose(sda_oe_n)
      |-> !st_reg.scl_s2 || $past(start_cond || stop_cond))
      else $error("data line released while clock high");

endmodule

// [dv/i2c_host_model.sv]
// Purpose: Behavioural host that drives the serial bus as controller.
// Assumes: Open-drain data line with pull-up; the resolved level comes back on sda.
// Notes: Serial clock stands high between frames; each byte result pulses rsp_valid.
module i2c_host_model (
   // Clock
   input wire logic clk,
   // Serial bus
   input wire logic sda,
   output logic scl,
   output logic sda_low,
   // Observed results
   output logic rsp_valid,
   output logic [7:0] rsp_data
);
   timeunit 1ns;
   timeprecision 100ps;

   localparam int QTR = 4; // Quarter of a 160 ns serial period

   // Idle bus at time zero
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
      rsp_valid = 1'b0;
      rsp_data = 8'h00;
   end

   // Wait core clocks, then step off the edge
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // One bit slot; data only changes while the serial clock is low
   task automatic bit_slot(input logic b, output logic s);
      sda_low = !b;
      wait_clk(QTR);
      scl = 1'b1;
      wait_clk(QTR);
      s = sda;
      wait_clk(QTR);
      scl = 1'b0;
      wait_clk(QTR);
   endtask

   // Start or repeated start
   task automatic start();
      sda_low = 1'b0;
      wait_clk(QTR);
      scl = 1'b1;
      wait_clk(QTR);
      sda_low = 1'b1;
      wait_clk(QTR);
      scl = 1'b0;
      wait_clk(QTR);
   endtask

   // Stop, then the bus is left free with both lines high
   task automatic stop();
      sda_low = 1'b1;
      wait_clk(QTR);
      scl = 1'b1;
      wait_clk(QTR);
      sda_low = 1'b0;
      wait_clk(2 * QTR);
   endtask

   // Hand one result to the bench for one cycle
   task automatic post(input logic [7:0] v);
      rsp_data = v;
      rsp_valid = 1'b1;
      wait_clk(1);
      rsp_valid = 1'b0;
   endtask

   // Send a byte MSB first and report the acknowledge level
   task automatic write_byte(input logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_slot(d[i], s);
      bit_slot(1'b1, s);
      post({7'h00, s});
   endtask

   // Receive a byte and answer it; last byte gets not-acknowledge
   task automatic read_byte(input logic last);
      logic [7:0] d;
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_slot(1'b1, s);
         d[i] = s;
      end
      bit_slot(last, s);
      post(d);
   endtask
endmodule

// [dv/test_i2c_target.sv]
// Purpose: Self-checking bench for the register-pointer serial target.
// Assumes: Host model drives the bus; pull-up on the data line.
// Notes: Expected results are queued and matched in order by a monitor.
`include "i2c_target_map.svh"

module test_i2c_target;
   timeunit 1ns;
   timeprecision 100ps;

   typedef struct {
      string nm;
      logic [7:0] v;
   } note_type;

   localparam int LIMIT = 30000;
   logic clk, nrst, scl, sda, sda_out, sda_oe_n, sda_low, bank_hold, busy;
   logic rsp_valid, probe_valid;
   logic [7:0] core_addr, core_rdata, ptr_out, rsp_data, probe_data, mon_got;
   logic [7:0] dat [0:8];
   note_type notes[$];
   note_type mon_note;
   int seed = 18;
   int num_errors = 0;
   int num_checks = 0;
   int cycles = 0;

   // Open-drain data line with pull-up
   assign sda = !((!sda_oe_n && !sda_out) || sda_low);

   i2c_target i2c_target_inst (
      .clk(clk), .nrst(nrst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .bank_hold(bank_hold), .core_addr(core_addr),
      .core_rdata(core_rdata), .ptr_out(ptr_out), .busy(busy)
   );

   i2c_host_model i2c_host_model_inst (
      .clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data)
   );

   // Core clock, 100 MHz
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Verdict and end of run
   task automatic summarize();
      if (num_errors == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Bench helpers
   task automatic w(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic note(input string nm, input logic [7:0] v);
      notes.push_back('{nm, v});
   endtask
   task automatic wb(input logic [7:0] d, input logic nack);
      note("ack", {7'h00, nack});
      i2c_host_model_inst.write_byte(d);
   endtask
   task automatic rb(input logic [7:0] d, input logic last);
      note("read data", d);
      i2c_host_model_inst.read_byte(last);
   endtask
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      note(nm, exp);
      probe_data = got;
      probe_valid = 1'b1;
      w(1);
      probe_valid = 1'b0;
      w(1); // Let an edge pass before the next probe
   endtask
   task automatic core_rd(input logic [7:0] a, input logic [7:0] exp);
      core_addr = a;
      w(2);
      chk("core data", exp, core_rdata);
   endtask
   task automatic fill();
      for (int i = 0; i < 9; i++)
         dat[i] = 8'($random(seed));
   endtask
   // Pointer byte first, then n data bytes of which n_ack are accepted
   task automatic put(input logic [7:0] p, input int n, input int n_ack);
      i2c_host_model_inst.start();
      wb({`TARGET_ADDR, 1'b0}, 1'b0);
      wb(p, 1'b0);
      for (int i = 0; i < n; i++)
         wb(dat[i], i >= n_ack);
      i2c_host_model_inst.stop();
   endtask
   // Pointer write, repeated start, then n reads
   task automatic get(input logic [7:0] p, input int n);
      i2c_host_model_inst.start();
      wb({`TARGET_ADDR, 1'b0}, 1'b0);
      wb(p, 1'b0);
      i2c_host_model_inst.start();
      wb({`TARGET_ADDR, 1'b1}, 1'b0);
      for (int i = 0; i < n; i++)
         rb(dat[i], i == n - 1);
      i2c_host_model_inst.stop();
   endtask

   // Main sequence
   initial
   begin
      nrst = 1'b0;
      bank_hold = 1'b0;
      core_addr = 8'h00;
      probe_valid = 1'b0;
      probe_data = 8'h00;
      w(6);
      nrst = 1'b1;
      w(4);
      chk("pointer", `PTR_RESET, ptr_out);
      chk("busy", 8'h00, {7'h00, busy});
      i2c_host_model_inst.start();
      chk("busy", 8'h01, {7'h00, busy});
      wb({`TARGET_ADDR ^ 7'h01, 1'b0}, 1'b1);
      chk("busy", 8'h00, {7'h00, busy});
      i2c_host_model_inst.stop();
      fill();
      put(`SCRATCH_TEST_0_OFS, 4, 4);
      get(`SCRATCH_TEST_0_OFS, 4);
      chk("pointer", `SCRATCH_TEST_3_OFS + 8'h01, ptr_out);
      nrst = 1'b0;
      w(6);
      nrst = 1'b1;
      w(4);
      chk("pointer", `PTR_RESET, ptr_out);
      fill();
      put(8'hFE, 3, 3);
      core_rd(8'h00, dat[2]);
      get(8'hFE, 3);
      chk("pointer", 8'h01, ptr_out);
      bank_hold = 1'b1;
      fill();
      put(8'h10, 9, 8);
      chk("pointer", 8'h18, ptr_out);
      bank_hold = 1'b0;
      w(20);
      core_rd(8'h17, dat[7]);
      get(8'h10, 8);
      w(10);
      if (notes.size() != 0)
      begin
         num_errors++;
         $display("[ERR] pending results expected 0 seen %0d", notes.size());
      end
      summarize();
   end

   // Match each result against the oldest queued note
   always @(posedge clk)
   begin
      if (rsp_valid || probe_valid)
      begin
         mon_got = rsp_valid ? rsp_data : probe_data;
         if (notes.size() == 0)
            mon_note = '{"unexpected result", 8'hXX};
         else
            mon_note = notes.pop_front();
         num_checks++;
         if (mon_note.v !== mon_got)
         begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", mon_note.nm, mon_note.v, mon_got);
         end
      end
   end

   // Cut a hang short
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         num_errors++;
         $display("[ERR] cycle limit expected %0d seen %0d", LIMIT - 1, cycles);
         summarize();
      end
   end
endmodule
